// ### tmr_pkg.sv
// constants shared by the buffered compare timer files
package tmr_pkg;
    localparam int CNT_W = 16;
    localparam int CH_N = 4;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_COUNT = 8'h04;
    localparam logic [7:0] A_MOD = 8'h08;
    localparam logic [7:0] A_CH_BASE = 8'h20;
    localparam logic [7:0] A_CH_MASK = 8'hE3;
    localparam int A_VAL_BIT = 2;
    localparam int A_CH_LSB = 3;
    // control register fields
    localparam int CTRL_STOP = 5;
    localparam int CTRL_CLR = 4;
    localparam int CTRL_PS_LSB = 0;
    localparam int PS_W = 3;
    localparam logic [7:0] CTRL_WMASK = 8'h27;
    // channel status/control fields
    localparam int SC_FLAG = 7;
    localparam int SC_BUF = 5;
    localparam int SC_OCEN = 4;
    localparam int SC_ELSB = 3;
    localparam int SC_ELSA = 2;
    localparam int SC_TOV = 1;
    localparam logic [7:0] SC_WMASK_EVEN = 8'h3E;
    localparam logic [7:0] SC_WMASK_ODD = 8'h1E;
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h20;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [7:0] SC_RST = 8'h00;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam logic [6:0] PSC_RST = 7'h00;
endpackage : tmr_pkg

// ### cnt_if.sv
// counter state shared between the counter and the channel logic
`timescale 1ns/1ps
`default_nettype none
interface cnt_if;
    logic [15:0] count;
    logic tick;
    logic ovf;
    modport src(output count, output tick, output ovf);
    modport dst(input count, input tick, input ovf);
endinterface : cnt_if
`default_nettype wire

// ### tmr_counter.sv
// prescaled free-running counter with modulo wrap
`timescale 1ns/1ps
`default_nettype none
module tmr_counter (
    input wire logic clk, // bus clock
    input wire logic rst_n, // async reset, active low
    input wire logic run, // counting enabled
    input wire logic clr, // one-cycle counter clear
    input wire logic [2:0] ps, // prescale exponent
    input wire logic [15:0] modulo, // wrap value
    cnt_if.src cnt // count, tick and overflow
);
    typedef struct packed {
        logic [6:0] psc;
        logic [15:0] count;
    } cstate_t;
    cstate_t state_reg;
    cstate_t state_next;
    logic [6:0] limit;

    // prescaled tick, overflow when the tick lands on the modulo value
    assign limit = 7'((8'h01 << ps) - 8'h01);
    assign cnt.count = state_reg.count;
    assign cnt.tick = run && (state_reg.psc == limit);
    assign cnt.ovf = cnt.tick && (state_reg.count == modulo); // [RULE12]

    always_comb begin
        state_next = state_reg;
        if (clr) begin
            state_next.psc = tmr_pkg::PSC_RST;
            state_next.count = 16'h0000;
        end else if (run) begin
            state_next.psc = cnt.tick ? tmr_pkg::PSC_RST : 7'(state_reg.psc + 7'h01);
            if (cnt.ovf) begin
                state_next.count = 16'h0000; // [RULE16]
            end else if (cnt.tick) begin
                state_next.count = 16'(state_reg.count + 16'h0001); // [RULE16]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        (cnt.ovf && !clr) |=> (state_reg.count == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap at modulo"); // [RULE12]

    property p_inc;
        @(posedge clk) disable iff (!rst_n)
        (cnt.tick && !cnt.ovf && !clr) |=> (state_reg.count == $past(state_reg.count) + 16'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not step on tick"); // [RULE16]
endmodule : tmr_counter
`default_nettype wire

// ### pair_sel.sv
// active-channel tracking for one buffered compare pair
`timescale 1ns/1ps
`default_nettype none
module pair_sel (
    input wire logic clk, // bus clock
    input wire logic rst_n, // async reset, active low
    input wire logic link, // pair linked by buffer mode
    input wire logic wr_even, // value write to even channel
    input wire logic wr_odd, // value write to odd channel
    input wire logic ovf, // counter overflow
    output var logic active_odd // odd channel drives the output
);
    typedef struct packed {
        logic active;
        logic last;
    } pstate_t;
    pstate_t state_reg;
    pstate_t state_next;

    // the swap waits for overflow so a counter period never sees a mixed value
    always_comb begin
        state_next = state_reg;
        if (!link) begin
            state_next = '0;
        end else begin
            if (ovf) begin
                state_next.active = state_reg.last; // [RULE1] [RULE2] [RULE7]
            end
            if (wr_odd) begin
                state_next.last = 1'b1;
            end else if (wr_even) begin
                state_next.last = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_odd = state_reg.active;

    property p_swap;
        @(posedge clk) disable iff (!rst_n)
        (link && ovf) |=> (state_reg.active == $past(state_reg.last));
    endproperty
    a_swap: assert property (p_swap) else $error("pair did not swap to last written"); // [RULE2]

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (link && !ovf) |=> $stable(state_reg.active);
    endproperty
    a_hold: assert property (p_hold) else $error("pair swapped without overflow"); // [RULE1]
endmodule : pair_sel
`default_nettype wire

// ### buffered_compare_pwm.sv
// four-channel output compare timer with buffered pairs and PWM
// Function
// RULE1: channel 1 write hands pair output over at overflow
// RULE2: each overflow, last-written channel drives pair
// RULE3: linked 0/1 uses channel 0 control only
// RULE4: linked 0/1 releases channel 1 pin
// RULE5: channel 2 buffer bit links 2/3 on pin 2
// RULE6: channel 2 value drives pin 2 first
// RULE7: channel 3 write takes over at next overflow
// RULE8: linked 2/3 ignores channel 3 control, frees pin
// RULE9: writing active channel acts immediately, unbuffered
// RULE10: software writes only the inactive channel
// RULE11: toggle-on-overflow toggles pin at modulo
// RULE12: modulo value sets the PWM period
// RULE13: overflow to match sets the pulse width
// RULE14: polarity 1 PWM clears pin on match
// RULE15: polarity 0 PWM sets pin on match
// RULE16: counter steps, wraps at modulo, matches value
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module buffered_compare_pwm (
    input wire logic clk, // bus clock, 200 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    output logic [3:0] chan_pin, // channel pin levels
    output logic [3:0] chan_pin_oe // high while the timer drives the pin
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] modv;
        logic [3:0][7:0] sc;
        logic [3:0][15:0] val;
        logic [3:0] pin;
        logic [3:0] oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;
    state_t state_reg;
    state_t state_next;

    cnt_if cnt();
    logic setup;
    logic acc;
    logic wr;
    logic clr;
    logic [1:0] ch;
    logic [3:0] wr_val;
    logic [3:0] wr_sc;
    logic [3:0] match;
    logic [3:0] quiet;
    logic [3:0][15:0] cmp;
    logic [1:0] link;
    logic [1:0] act;

    // channel register window decode, shared by read and write paths
    function automatic logic is_ch(input logic [7:0] a);
        return (a & tmr_pkg::A_CH_MASK) == tmr_pkg::A_CH_BASE;
    endfunction : is_ch

    function automatic logic hit(input logic [7:0] a);
        return (a == tmr_pkg::A_CTRL) || (a == tmr_pkg::A_COUNT) ||
            (a == tmr_pkg::A_MOD) || is_ch(a);
    endfunction : hit

    function automatic logic [31:0] rd_word(input state_t st, input logic [7:0] a,
                                            input logic [15:0] c);
        logic [31:0] d;
        d = tmr_pkg::RD_ZERO;
        if (a == tmr_pkg::A_CTRL) begin
            d = {24'h000000, st.ctrl};
        end else if (a == tmr_pkg::A_COUNT) begin
            d = {16'h0000, c};
        end else if (a == tmr_pkg::A_MOD) begin
            d = {16'h0000, st.modv};
        end else if (is_ch(a)) begin
            if (a[tmr_pkg::A_VAL_BIT]) begin
                d = {16'h0000, st.val[a[4:3]]};
            end else begin
                d = {24'h000000, st.sc[a[4:3]]};
            end
        end
        return d;
    endfunction : rd_word

    // pin action on overflow and match; match wins over the overflow toggle
    function automatic logic pin_step(input logic [7:0] sc, input logic p,
                                      input logic m, input logic o);
        logic q;
        q = p;
        if (o && sc[tmr_pkg::SC_TOV]) begin
            q = ~p; // [RULE11]
        end
        if (m) begin
            unique case ({sc[tmr_pkg::SC_ELSB], sc[tmr_pkg::SC_ELSA]})
                2'b01: q = ~p;
                2'b10: q = 1'b0; // [RULE14]
                2'b11: q = 1'b1; // [RULE15]
                2'b00: q = q;
            endcase
        end
        return q;
    endfunction : pin_step

    tmr_counter u_counter (
        .clk(clk),
        .rst_n(rst_n),
        .run(!state_reg.ctrl[tmr_pkg::CTRL_STOP]),
        .clr(clr),
        .ps(state_reg.ctrl[tmr_pkg::CTRL_PS_LSB +: tmr_pkg::PS_W]),
        .modulo(state_reg.modv),
        .cnt(cnt.src)
    );

    // one tracker per pair, channels 2p and 2p+1
    for (genvar gp = 0; gp < 2; gp++) begin : g_pair
        pair_sel u_pair (
            .clk(clk),
            .rst_n(rst_n),
            .link(link[gp]),
            .wr_even(wr_val[2*gp]),
            .wr_odd(wr_val[2*gp+1]),
            .ovf(cnt.ovf),
            .active_odd(act[gp])
        );
    end

    // bus strobes; a write lands on the edge that also samples pready
    assign setup = psel && !penable;
    assign acc = psel && penable && state_reg.pready;
    assign wr = acc && pwrite;
    assign ch = paddr[4:3];
    assign clr = wr && (paddr == tmr_pkg::A_CTRL) && pwdata[tmr_pkg::CTRL_CLR];
    assign link[0] = state_reg.sc[0][tmr_pkg::SC_BUF]; // [RULE3]
    assign link[1] = state_reg.sc[2][tmr_pkg::SC_BUF]; // [RULE5]

    // compare selection and match detection per channel
    always_comb begin
        for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            wr_val[i] = wr && is_ch(paddr) && paddr[tmr_pkg::A_VAL_BIT] && (ch == 2'(i));
            wr_sc[i] = wr && is_ch(paddr) && !paddr[tmr_pkg::A_VAL_BIT] && (ch == 2'(i));
            // odd channel of a linked pair is silent; its control has no say
            quiet[i] = (i % 2 == 1) && link[i / 2]; // [RULE3] [RULE8]
            if ((i % 2 == 0) && link[i / 2] && act[i / 2]) begin
                cmp[i] = state_reg.val[i + 1]; // [RULE7] [RULE1]
            end else begin
                cmp[i] = state_reg.val[i]; // [RULE6] [RULE9]
            end
            match[i] = cnt.tick && (cnt.count == cmp[i]) && !quiet[i] &&
                state_reg.sc[i][tmr_pkg::SC_OCEN]; // [RULE16] [RULE13]
        end
    end

    // register file, pins and bus answer
    always_comb begin
        state_next = state_reg;
        state_next.pready = setup;
        state_next.pslverr = setup && !hit(paddr);
        state_next.prdata = (setup && !pwrite) ? rd_word(state_reg, paddr, cnt.count) :
            tmr_pkg::RD_ZERO;
        if (wr && (paddr == tmr_pkg::A_CTRL)) begin
            state_next.ctrl = pwdata[7:0] & tmr_pkg::CTRL_WMASK;
        end
        if (wr && (paddr == tmr_pkg::A_MOD)) begin
            state_next.modv = pwdata[15:0]; // [RULE12]
        end
        for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            if (wr_val[i]) begin
                state_next.val[i] = pwdata[15:0]; // [RULE9]
            end
            if (wr_sc[i]) begin
                // flag clears only by writing zero to it
                state_next.sc[i] = (pwdata[7:0] & ((i % 2 == 0) ? tmr_pkg::SC_WMASK_EVEN :
                    tmr_pkg::SC_WMASK_ODD)) | {state_reg.sc[i][tmr_pkg::SC_FLAG] &&
                    pwdata[tmr_pkg::SC_FLAG], 7'h00};
            end
            if (match[i]) begin
                state_next.sc[i][tmr_pkg::SC_FLAG] = 1'b1; // set wins over clear
            end
            if (!quiet[i]) begin
                state_next.pin[i] = pin_step(state_reg.sc[i], state_reg.pin[i], match[i],
                    cnt.ovf); // [RULE11] [RULE13]
            end
            state_next.oe[i] = !quiet[i] && state_reg.sc[i][tmr_pkg::SC_OCEN] &&
                (state_reg.sc[i][tmr_pkg::SC_ELSB] ||
                state_reg.sc[i][tmr_pkg::SC_ELSA]); // [RULE4] [RULE8]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.ctrl <= tmr_pkg::CTRL_RST;
            state_reg.modv <= tmr_pkg::MOD_RST;
            state_reg.sc <= {tmr_pkg::CH_N{tmr_pkg::SC_RST}};
            state_reg.val <= {tmr_pkg::CH_N{tmr_pkg::VAL_RST}};
            state_reg.pin <= 4'h0;
            state_reg.oe <= 4'h0;
            state_reg.prdata <= tmr_pkg::RD_ZERO;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign chan_pin = state_reg.pin;
    assign chan_pin_oe = state_reg.oe;

    property p_rel1;
        @(posedge clk) disable iff (!rst_n)
        link[0] |=> !chan_pin_oe[1];
    endproperty
    a_rel1: assert property (p_rel1) else $error("pin 1 driven while pair linked"); // [RULE4]

    property p_rel3;
        @(posedge clk) disable iff (!rst_n)
        link[1] |=> !chan_pin_oe[3];
    endproperty
    a_rel3: assert property (p_rel3) else $error("pin 3 driven while pair linked"); // [RULE8]

    property p_sc1_dead;
        @(posedge clk) disable iff (!rst_n)
        link[0] |-> !match[1] ##1 !$rose(state_reg.sc[1][tmr_pkg::SC_FLAG]);
    endproperty
    a_sc1_dead: assert property (p_sc1_dead) else $error("channel 1 active in pair"); // [RULE3]

    property p_take23;
        @(posedge clk) disable iff (!rst_n)
        (link[1] && act[1]) |-> (cmp[2] == state_reg.val[3]);
    endproperty
    a_take23: assert property (p_take23) else $error("channel 3 value not used"); // [RULE7]

    property p_init23;
        @(posedge clk) disable iff (!rst_n)
        $rose(link[1]) |-> (cmp[2] == state_reg.val[2]) [*2];
    endproperty
    a_init23: assert property (p_init23) else $error("pair 2/3 did not start on 2"); // [RULE6]

    property p_direct;
        @(posedge clk) disable iff (!rst_n)
        (link[0] && wr_val[0] && !act[0] && !cnt.ovf) |=> (cmp[0] == $past(pwdata[15:0]));
    endproperty
    a_direct: assert property (p_direct) else $error("active write deferred"); // [RULE9]

    property p_tov;
        @(posedge clk) disable iff (!rst_n)
        (cnt.ovf && !match[0] && state_reg.sc[0][tmr_pkg::SC_TOV] && !quiet[0])
            |=> (chan_pin[0] != $past(chan_pin[0]));
    endproperty
    a_tov: assert property (p_tov) else $error("pin 0 did not toggle at overflow"); // [RULE11]

    property p_clr2;
        @(posedge clk) disable iff (!rst_n)
        (link[1] && match[2] && state_reg.sc[2][tmr_pkg::SC_ELSB] &&
            !state_reg.sc[2][tmr_pkg::SC_ELSA]) |=> !chan_pin[2];
    endproperty
    a_clr2: assert property (p_clr2) else $error("buffered pin 2 not cleared"); // [RULE5] [RULE13]

    // odd pins of a linked pair keep their level, so software may reuse them
    property p_hold1;
        @(posedge clk) disable iff (!rst_n)
        link[0] |=> (chan_pin[1] == $past(chan_pin[1]));
    endproperty
    a_hold1: assert property (p_hold1) else $error("pin 1 moved in pair"); // [RULE4]

    property p_hold3;
        @(posedge clk) disable iff (!rst_n)
        link[1] |=> (chan_pin[3] == $past(chan_pin[3]));
    endproperty
    a_hold3: assert property (p_hold3) else $error("pin 3 moved in pair"); // [RULE8]

    property p_sc3_dead;
        @(posedge clk) disable iff (!rst_n)
        link[1] |-> !match[3] ##1 !$rose(state_reg.sc[3][tmr_pkg::SC_FLAG]);
    endproperty
    a_sc3_dead: assert property (p_sc3_dead) else $error("channel 3 active in pair"); // [RULE8]

    // compare source of each pair: even first, odd once handed over
    property p_init01;
        @(posedge clk) disable iff (!rst_n)
        $rose(link[0]) |-> (cmp[0] == state_reg.val[0]) [*2];
    endproperty
    a_init01: assert property (p_init01) else $error("pair 0/1 did not start on 0"); // [RULE1]

    property p_take01;
        @(posedge clk) disable iff (!rst_n)
        (link[0] && act[0]) |-> (cmp[0] == state_reg.val[1]);
    endproperty
    a_take01: assert property (p_take01) else $error("channel 1 value not used"); // [RULE1]

    property p_direct23;
        @(posedge clk) disable iff (!rst_n)
        (link[1] && wr_val[2] && !act[1] && !cnt.ovf) |=> (cmp[2] == $past(pwdata[15:0]));
    endproperty
    a_direct23: assert property (p_direct23) else $error("pair 2/3 write deferred"); // [RULE9]

    property p_oe2;
        @(posedge clk) disable iff (!rst_n)
        (link[1] && state_reg.sc[2][tmr_pkg::SC_OCEN] && state_reg.sc[2][tmr_pkg::SC_ELSB])
            |=> chan_pin_oe[2];
    endproperty
    a_oe2: assert property (p_oe2) else $error("buffered pin 2 not driven"); // [RULE5]

    // match actions; a lost flag would hide a match from software
    property p_flag0;
        @(posedge clk) disable iff (!rst_n)
        match[0] |=> state_reg.sc[0][tmr_pkg::SC_FLAG];
    endproperty
    a_flag0: assert property (p_flag0) else $error("match did not set flag 0"); // [RULE16]

    property p_clr0;
        @(posedge clk) disable iff (!rst_n)
        (match[0] && state_reg.sc[0][tmr_pkg::SC_ELSB] && !state_reg.sc[0][tmr_pkg::SC_ELSA])
            |=> !chan_pin[0];
    endproperty
    a_clr0: assert property (p_clr0) else $error("pin 0 not cleared on match"); // [RULE13]

    property p_set1;
        @(posedge clk) disable iff (!rst_n)
        (match[1] && state_reg.sc[1][tmr_pkg::SC_ELSB] && state_reg.sc[1][tmr_pkg::SC_ELSA])
            |=> chan_pin[1];
    endproperty
    a_set1: assert property (p_set1) else $error("pin 1 not set on match"); // [RULE13]

    property p_tog0;
        @(posedge clk) disable iff (!rst_n)
        (match[0] && !state_reg.sc[0][tmr_pkg::SC_ELSB] && state_reg.sc[0][tmr_pkg::SC_ELSA])
            |=> (chan_pin[0] != $past(chan_pin[0]));
    endproperty
    a_tog0: assert property (p_tog0) else $error("pin 0 did not toggle on match"); // [RULE16]

    c_swap01: cover property (@(posedge clk) disable iff (!rst_n) $rose(act[0]));
    c_swap23: cover property (@(posedge clk) disable iff (!rst_n) link[1] && $fell(act[1]));
    c_pwm: cover property (@(posedge clk) disable iff (!rst_n) cnt.ovf ##[1:40] match[0]);
    c_tog0: cover property (@(posedge clk) disable iff (!rst_n)
        match[0] && !state_reg.sc[0][tmr_pkg::SC_ELSB]);
    c_direct23: cover property (@(posedge clk) disable iff (!rst_n)
        link[1] && wr_val[2] && !act[1]);
endmodule : buffered_compare_pwm
`default_nettype wire

// ### buffered_compare_pwm_test.sv
// self-checking bench for the buffered compare pwm timer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module buffered_compare_pwm_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] chan_pin;
    logic [3:0] chan_pin_oe;
    logic [3:0] prev_pin = 4'h0;
    logic [31:0] rdv;
    logic errv;
    int n_fail = 0;
    int checks_done = 0;
    int rises[4];
    int falls[4];
    int last_hi[4];
    int last_per[4];
    int hi_run[4];
    int since_rise[4];

    // 200 MHz bus clock
    always #2.5 clk = ~clk;

    buffered_compare_pwm buffered_compare_pwm_inst (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .chan_pin(chan_pin),
        .chan_pin_oe(chan_pin_oe)
    );

    // pin monitor on the falling edge, away from the design's updates
    always @(negedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (chan_pin[i] === 1'b1 && prev_pin[i] !== 1'b1) begin
                last_per[i] = since_rise[i];
                since_rise[i] = 0;
                hi_run[i] = 0;
                rises[i]++;
            end
            if (chan_pin[i] !== 1'b1 && prev_pin[i] === 1'b1) begin
                last_hi[i] = hi_run[i];
                falls[i]++;
            end
            since_rise[i]++;
            if (chan_pin[i] === 1'b1) begin
                hi_run[i]++;
            end
            prev_pin[i] = chan_pin[i];
        end
    end

    function automatic logic [7:0] sc_addr(input int n);
        return tmr_pkg::A_CH_BASE + 8'(8 * n);
    endfunction : sc_addr

    function automatic logic [7:0] val_addr(input int n);
        return sc_addr(n) + 8'h04;
    endfunction : val_addr

    // high time: overflow to match when clearing, match to overflow when setting
    function automatic int exp_hi(input int m, input int w, input int ps, input bit pol1);
        return (pol1 ? w + 1 : m - w) << ps;
    endfunction : exp_hi

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic fail_out(input string msg);
        n_fail++;
        $display("BAD %0t %s", $time, msg);
        finish_test();
    endtask : fail_out

    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_out("apb answer missing");
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // counts pin edges seen by the monitor; bounded so a dead pin ends the run
    task automatic wait_edge(input int ch, input int n, input bit rise);
        int base;
        int k;
        base = rise ? rises[ch] : falls[ch];
        k = 0;
        while ((rise ? rises[ch] : falls[ch]) < base + n) begin
            @(posedge clk);
            k++;
            if (k > 3000) begin
                fail_out("pin edge missing");
            end
        end
    endtask : wait_edge

    initial begin
        int m, ps, a, b, c, d, e, o;
        int w[4];
        void'($urandom(57));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        // reset state of pin enables and registers, plus an unmapped access
        `CHECK(chan_pin_oe, 4'h0)
        rd(tmr_pkg::A_CTRL);
        `CHECK(rdv, {24'h0, tmr_pkg::CTRL_RST})
        rd(tmr_pkg::A_MOD);
        `CHECK(rdv, {16'h0, tmr_pkg::MOD_RST})
        for (int i = 0; i < 4; i++) begin
            rd(sc_addr(i));
            `CHECK(rdv, {24'h0, tmr_pkg::SC_RST})
            rd(val_addr(i));
            `CHECK(rdv, {16'h0, tmr_pkg::VAL_RST})
        end
        rd(8'h10);
        `CHECK({errv, rdv}, {1'b1, tmr_pkg::RD_ZERO})
        $display("test reset done");

        // all four channels as pwm, random period and prescale, edge widths
        m = 10 + int'($urandom % 6);
        ps = int'($urandom % 3);
        w[0] = 0;
        w[1] = 1 + int'($urandom % (m - 2));
        w[2] = 1 + int'($urandom % (m - 2));
        w[3] = m - 1;
        wr(tmr_pkg::A_MOD, 32'(m));
        for (int i = 0; i < 4; i++) begin
            wr(val_addr(i), 32'(w[i]));
            // even channels clear on match, odd ones set on match
            wr(sc_addr(i), (i % 2 == 0) ? 32'h0000_001A : 32'h0000_001E);
        end
        wr(tmr_pkg::A_CTRL, 32'(ps));
        for (int i = 0; i < 4; i++) begin
            wait_edge(i, 3, 1'b0);
            `CHECK(last_hi[i], exp_hi(m, w[i], ps, i % 2 == 0))
            `CHECK(last_per[i], (m + 1) << ps)
        end
        rd(sc_addr(0));
        `CHECK(rdv[7], 1'b1)
        rd(tmr_pkg::A_COUNT);
        `CHECK(rdv[15:0] <= 16'(m), 1'b1)
        wr(tmr_pkg::A_CTRL, 32'h0000_0030);
        $display("test pwm done");

        // each pair linked in turn; handovers only at overflow
        for (int p = 0; p < 2; p++) begin
            e = 2 * p;
            o = e + 1;
            a = 5 + int'($urandom % 8);
            b = 5 + int'($urandom % 8);
            c = 5 + int'($urandom % 8);
            d = (c >= 9) ? c - 3 : c + 3;
            wr(tmr_pkg::A_MOD, 32'h0000_000F);
            wr(sc_addr(o), 32'h0000_001A);
            wr(val_addr(e), 32'(a));
            wr(sc_addr(e), 32'h0000_003A);
            // odd control written while linked must have no effect
            wr(sc_addr(o), 32'h0000_001E);
            repeat (3) @(posedge clk);
            `CHECK(chan_pin_oe[o], 1'b0)
            `CHECK(chan_pin_oe[e], 1'b1)
            wr(tmr_pkg::A_CTRL, 32'h0000_0000);
            wait_edge(e, 3, 1'b0);
            `CHECK(last_hi[e], a + 1)
            `CHECK(last_per[e], 16)
            wr(val_addr(o), 32'(b));
            wait_edge(e, 2, 1'b0);
            `CHECK(last_hi[e], b + 1)
            wr(val_addr(e), 32'(c));
            wait_edge(e, 2, 1'b0);
            `CHECK(last_hi[e], c + 1)
            // write the active channel early in a period: it must bite now
            wait_edge(e, 1, 1'b1);
            wr(val_addr(e), 32'(d));
            wait_edge(e, 1, 1'b0);
            `CHECK(last_hi[e], d + 1)
            `CHECK(chan_pin_oe[o], 1'b0)
            wr(sc_addr(e), 32'h0000_0000);
            wr(tmr_pkg::A_CTRL, 32'h0000_0030);
            $display("test pair %0d done", p);
        end

        // toggle on match alone: a square wave of two counter periods
        wr(val_addr(0), 32'h0000_0007);
        wr(sc_addr(0), 32'h0000_0014);
        wr(tmr_pkg::A_CTRL, 32'h0000_0000);
        wait_edge(0, 3, 1'b0);
        `CHECK(last_hi[0], 16)
        `CHECK(last_per[0], 32)
        wr(tmr_pkg::A_CTRL, 32'h0000_0030);
        wr(sc_addr(0), 32'h0000_0000);
        rd(sc_addr(0));
        `CHECK(rdv[7], 1'b0)
        $display("test toggle done");
        finish_test();
    end
endmodule : buffered_compare_pwm_test
`default_nettype wire
